// *** verilog/slw_spi_alert.sv ***
// Purpose: SPI slave port and limit alert output of a monitoring device
// Assumes: sclk runs only inside frames; register file lives outside
// Notes: Link logic on sclk, register and alert logic on clk
// How it works
// R1 - 0x90 is write, 0x91 is read
// R2 - Sample serial input on rising sclk
// R3 - Drive serial output on falling sclk
// R4 - Ignore input until chip select falls
// R5 - Chip select high tristates both data lines
// R6 - Write: command, address, then sequential data
// R7 - Pointer increments per byte, wraps at 0x3F
// R8 - Read preceded by pointer-loading write
// R9 - Read: command byte, then pointed register
// R10 - Continued clocking reads successive registers
// R11 - Host toggles chip select between transactions
// R12 - Polarity bit sets alert level, default low
// R13 - Disable bit high turns alert off; code only releases the line, which reads active when polarity is high
// R14 - Any limit crossing asserts the alert
// R15 - Clear needs back-in-limits and status read
// R16 - Two status registers record event sources
// R17 - Open drain, wire-AND only when active low
// R18 - Asserting device answers alert response read
// R19 - Answer is seven-bit address with LSB 1
// R20 - Lowest address wins by bus arbitration
// R21 - Release after answer only if cleared
// R22 - Master repeats alert response while line low
// R23 - Third chip-select rise locks SPI mode
// R24 - Lock bit 0 at 0x7F reads one
// R25 - Chip select rising mid-byte discards partial byte
`timescale 1ns/1ps
`include "slw_defs.svh"
module slw_spi_alert #(
  parameter int NSRC = `SLW_NSRC,
  parameter logic [6:0] DEV_ADDR = 7'h48 // Arbitrary default bus address
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic din,
  output logic din_oe,
  output logic dout_o,
  output logic dout_oe,
  output logic wr_stb,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [5:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic spi_locked,
  output logic [7:0] lock_status,
  input wire logic [7:0] ctrl_cfg1,
  input wire logic [NSRC-1:0] over_upper_limit,
  input wire logic [NSRC-1:0] under_lower_limit,
  input wire logic conv_done,
  input wire logic stat1_rd,
  input wire logic stat2_rd,
  output logic [7:0] int_status1,
  output logic [7:0] int_status2,
  input wire logic ara_req,
  output logic [7:0] ara_resp,
  output logic ara_ack,
  output logic irq_o,
  output logic irq_oe
);
  // Link domain on sclk; chip select high clears the frame state
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [6:0] shift_r;
  slw_pkg::slw_phase_t phase_r;
  slw_pkg::slw_phase_t phase_nxt;
  logic is_read_r;
  logic is_read_nxt;
  logic drop_r;
  logic drop_nxt;
  logic [5:0] ptr_r;
  logic [5:0] ptr_nxt;
  logic [5:0] wa_r;
  logic [7:0] wd_r;
  logic wtog_r;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic dout_r;
  logic dout_nxt;

  // Byte assembly and command decode
  wire [7:0] rx_byte = {shift_r, din};
  wire byte_end = (bit_cnt_r == 3'h7);
  wire cmd_is_write = !drop_r && (rx_byte == `SLW_CMD_WRITE); // R1
  wire cmd_is_read = !drop_r && (rx_byte == `SLW_CMD_READ); // R1
  wire in_adr = (phase_r == slw_pkg::SLW_ADR);
  wire in_wdat = (phase_r == slw_pkg::SLW_WDAT);
  wire in_rdat = (phase_r == slw_pkg::SLW_RDAT);
  wire adr_done = byte_end && in_adr; // R6 R8
  wire wdat_done = byte_end && in_wdat; // R6
  wire rdat_done = byte_end && in_rdat; // R10
  wire [5:0] ptr_inc = (ptr_r == `SLW_PTR_WRAP) ? `SLW_PTR_RESET : ptr_r + 6'h01; // R7
  assign bit_cnt_nxt = bit_cnt_r + 3'h1;

  // Bit counter and shifter; a cut byte is lost at chip select rise
  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin // R4 R25
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
    end else begin // R2
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= rx_byte[6:0];
    end
  end

  // Frame phase; an unknown command drops the rest of the frame
  always_comb begin
    phase_nxt = phase_r;
    is_read_nxt = is_read_r;
    drop_nxt = drop_r;
    if (byte_end) begin
      unique case (phase_r)
        slw_pkg::SLW_CMD: begin
          if (cmd_is_write) begin // R6 R8
            phase_nxt = slw_pkg::SLW_ADR;
          end else if (cmd_is_read) begin // R9
            phase_nxt = slw_pkg::SLW_RDAT;
            is_read_nxt = 1'b1;
          end else begin // R1
            drop_nxt = 1'b1;
          end
        end
        slw_pkg::SLW_ADR: phase_nxt = slw_pkg::SLW_WDAT;
        slw_pkg::SLW_WDAT: phase_nxt = slw_pkg::SLW_WDAT;
        slw_pkg::SLW_RDAT: phase_nxt = slw_pkg::SLW_RDAT;
      endcase
    end
  end

  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin // R4 R25
      phase_r <= slw_pkg::SLW_CMD;
      is_read_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      is_read_r <= is_read_nxt;
      drop_r <= drop_nxt;
    end
  end

  // Pointer moves only on completed bytes
  always_comb begin
    ptr_nxt = ptr_r;
    if (adr_done) begin // R6 R8
      ptr_nxt = rx_byte[5:0];
    end else if (wdat_done || rdat_done) begin // R7 R10
      ptr_nxt = ptr_inc;
    end
  end

  // Pointer and write toggle outlive frames, so only power-on clears them;
  // sclk is idle while rst_b moves, which keeps this clear safe
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r <= `SLW_PTR_RESET;
    end else if (!cs_b) begin
      ptr_r <= ptr_nxt;
    end
  end

  // Write word held steady a full byte while clk samples it
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      wa_r <= 6'h00;
      wd_r <= 8'h00;
      wtog_r <= 1'b0;
    end else if (!cs_b && wdat_done) begin // R6
      wa_r <= ptr_r;
      wd_r <= rx_byte;
      wtog_r <= ~wtog_r;
    end
  end

  assign rd_addr = ptr_r;

  // Read byte loads at the last falling edge of the byte before it
  wire load_tx = is_read_r && (bit_cnt_r == 3'h0); // R9 R10
  always_comb begin
    if (load_tx) begin
      dout_nxt = rd_data[7];
      tx_nxt = {rd_data[6:0], 1'b0};
    end else begin
      dout_nxt = tx_r[7];
      tx_nxt = {tx_r[6:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b) begin
      tx_r <= 8'h00;
      dout_r <= 1'b0;
    end else begin // R3
      dout_r <= dout_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign dout_o = dout_r;
  assign dout_oe = !cs_b && spi_locked; // R5
  assign din_oe = 1'b0; // R5

  // System domain on clk
  logic [1:0] sy;
  logic cs_q_r;
  logic wtog_q_r;
  logic [1:0] cs_rise_r;
  logic lock_r;
  slw_sync #(.W(2)) u_sync (
    .clk(clk),
    .d({cs_b, wtog_r}),
    .q(sy)
  );

  wire cs_rise = sy[1] && !cs_q_r;
  wire wr_evt = sy[0] ^ wtog_q_r;
  wire lock_step = cs_rise && !lock_r; // R23
  wire lock_hit = lock_step && (cs_rise_r == `SLW_LOCK_PULSES - 2'h1); // R23

  // Reset value matches idle chip select, so no false rise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_q_r <= 1'b1;
      wtog_q_r <= 1'b0;
    end else begin
      cs_q_r <= sy[1];
      wtog_q_r <= sy[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_rise_r <= 2'h0;
      lock_r <= 1'b0;
    end else begin
      if (lock_step) begin
        cs_rise_r <= cs_rise_r + 2'h1;
      end
      if (lock_hit) begin // R23
        lock_r <= 1'b1;
      end
    end
  end

  // Writes before lock are refused
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_stb <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= wr_evt && lock_r; // R23
      if (wr_evt) begin // R6
        wr_addr <= wa_r;
        wr_data <= wd_r;
      end
    end
  end

  assign spi_locked = lock_r;
  assign lock_status = {7'h00, lock_r}; // R24

  // Limit alert
  logic [7:0] st1_r;
  logic [7:0] st2_r;
  logic [7:0] st1_nxt;
  logic [7:0] st2_nxt;
  logic irq_act_r;
  logic [7:0] ara_resp_r;
  logic ara_ack_r;
  wire [7:0] st1_set = {{(8-NSRC){1'b0}}, over_upper_limit}; // R14 R16
  wire [7:0] st2_set = {{(8-NSRC){1'b0}}, under_lower_limit}; // R14 R16
  wire any_out = |(over_upper_limit | under_lower_limit);
  wire stat_clear = (st1_r == 8'h00) && (st2_r == 8'h00);
  wire irq_release = conv_done && stat_clear; // R15 R21
  wire ara_hit = ara_req && irq_act_r; // R18
  // Shared line arbitration favours the lower address bits sent first
  wire [7:0] ara_word = {DEV_ADDR, 1'b1}; // R19 R20

  // Per-bit sticky status; set wins over read clear
  for (genvar i = 0; i < 8; i++) begin : g_stat
    assign st1_nxt[i] = st1_set[i] || (st1_r[i] && !stat1_rd); // R16
    assign st2_nxt[i] = st2_set[i] || (st2_r[i] && !stat2_rd); // R16
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st1_r <= 8'h00;
      st2_r <= 8'h00;
    end else begin
      st1_r <= st1_nxt;
      st2_r <= st2_nxt;
    end
  end

  // A limit crossing outranks a release in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_act_r <= 1'b0;
    end else if (any_out) begin // R14
      irq_act_r <= 1'b1;
    end else if (irq_release) begin // R15 R21
      irq_act_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ara_resp_r <= 8'h00;
      ara_ack_r <= 1'b0;
    end else begin
      ara_ack_r <= ara_hit; // R18
      if (ara_hit) begin
        ara_resp_r <= ara_word; // R19
      end
    end
  end

  assign int_status1 = st1_r;
  assign int_status2 = st2_r;
  assign ara_resp = ara_resp_r;
  assign ara_ack = ara_ack_r;

  wire irq_en = !ctrl_cfg1[`SLW_DIS_BIT]; // R13
  wire irq_high = ctrl_cfg1[`SLW_POL_BIT]; // R12
  // Open drain: low level driven, high level from pull-up
  wire irq_level = irq_high ? irq_act_r : !irq_act_r;
  assign irq_o = 1'b0; // R17
  assign irq_oe = rst_b && irq_en && !irq_level; // R12 R17
endmodule : slw_spi_alert

// *** include/slw_defs.svh ***
// Purpose: Constants for the SPI slave with limit alert
// Assumes: Included by bare name
// Notes: Offsets and codes of the serial port
`ifndef SLW_DEFS_SVH
`define SLW_DEFS_SVH
`define SLW_CMD_WRITE 8'h90
`define SLW_CMD_READ 8'h91
`define SLW_PTR_WRAP 6'h3F
`define SLW_PTR_RESET 6'h00
`define SLW_LOCK_ADDR 7'h7F
`define SLW_LOCK_BIT 0
`define SLW_LOCK_PULSES 2'h3
`define SLW_ARA_ADDR 7'h0C
`define SLW_POL_BIT 6
`define SLW_DIS_BIT 5
`define SLW_NSRC 4
`endif

// *** include/slw_pkg.sv ***
// Purpose: Types for the SPI slave with limit alert
// Assumes: Nothing
// Notes: Link-side phase enumeration
package slw_pkg;
  typedef enum logic [1:0] {
    SLW_CMD = 2'b00,
    SLW_ADR = 2'b01,
    SLW_WDAT = 2'b10,
    SLW_RDAT = 2'b11
  } slw_phase_t;
endpackage : slw_pkg

// *** verilog/slw_sync.sv ***
// Purpose: Two-flop level synchroniser
// Assumes: Destination clock clk
// Notes: First stage read only by second stage
`timescale 1ns/1ps
module slw_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule : slw_sync

// *** sim/slw_spi_alert_properties.sv ***
// Purpose: Port assertions for the SPI slave
// Assumes: Bound into slw_spi_alert
// Notes: Alert checks for fixed config
`timescale 1ns/1ps
module slw_spi_alert_properties #(
  parameter int NSRC = 4,
  parameter logic [6:0] DEV_ADDR = 7'h48
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic dout_oe,
  input wire logic wr_stb,
  input wire logic spi_locked,
  input wire logic [7:0] ctrl_cfg1,
  input wire logic [NSRC-1:0] over_upper_limit,
  input wire logic [7:0] ara_resp,
  input wire logic ara_ack,
  input wire logic irq_o,
  input wire logic irq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_dout_released: assert property (cs_b [*3] |-> !dout_oe) else $error("dout on");
  a_irq_open_drain: assert property (irq_o == 1'b0) else $error("irq high");
  a_write_pulse: assert property (wr_stb |=> !wr_stb) else $error("long strobe");
  a_write_locked: assert property (wr_stb |-> spi_locked) else $error("unlocked");
  a_lock_held: assert property (spi_locked |=> spi_locked) else $error("lock lost");
  a_alert_raised: assert property
    ((|over_upper_limit) && ctrl_cfg1[6:5] == 2'b00 |-> ##[1:3] irq_oe) else $error("no irq");
  a_alert_off: assert property
    ((ctrl_cfg1[6:5] == 2'b01) [*3] |-> !irq_oe) else $error("irq on");
  a_ara_answer: assert property
    (ara_ack |=> ara_resp == {DEV_ADDR, 1'b1}) else $error("bad answer");
endmodule : slw_spi_alert_properties
bind slw_spi_alert slw_spi_alert_properties #(.NSRC(NSRC), .DEV_ADDR(DEV_ADDR)) chk_u (.clk,
  .rst_b, .cs_b, .dout_oe, .wr_stb, .spi_locked, .ctrl_cfg1, .over_upper_limit, .ara_resp,
  .ara_ack, .irq_o, .irq_oe);

// *** sim/slw_host_model.sv ***
// Purpose: Host SPI master model, mode 0
// Assumes: Called from the bench
// Notes: Released lines read pulled high
`timescale 1ns/1ps
module slw_host_model (
  output logic sclk = 1'b0,
  output logic cs_b = 1'b1,
  output logic din = 1'b1,
  input wire logic dout_o,
  input wire logic dout_oe
);
  logic [7:0] rx;
  task automatic sel(input logic v);
    #37 cs_b = v;
    din = 1'b1;
    #37;
  endtask : sel
  task automatic xfer(input logic [7:0] tx, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      din = tx[i];
      #15 sclk = 1'b1;
      rx[i] = dout_oe ? dout_o : 1'b1;
      #15 sclk = 1'b0;
    end
  endtask : xfer
endmodule : slw_host_model

// *** sim/spi_slave_with_limit_alert_bench.sv ***
// Purpose: Bench for the SPI slave
// Assumes: Register file is C0 or pointer
// Notes: Writes logged in a queue
`timescale 1ns/1ps
module spi_slave_with_limit_alert_bench;
  localparam logic [6:0] DEV = 7'h5A; // Arbitrary bus address
  logic clk, sclk, cs_b, din, din_oe, dout_o, dout_oe, wr_stb, spi_locked, ara_ack, irq_o, irq_oe;
  logic rst_b, conv_done = 1'b0, stat1_rd = 1'b0, stat2_rd = 1'b0, ara_req = 1'b0;
  logic [5:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, lock_status, int_status1, int_status2, ara_resp, ctrl_cfg1 = 8'h00;
  logic [3:0] over_upper_limit = 4'h0, under_lower_limit = 4'h0;
  logic [13:0] wq[$];
  int err_total = 0, checked = 0;
  slw_spi_alert #(.DEV_ADDR(DEV)) dut_u (.clk, .rst_b, .sclk, .cs_b, .din, .din_oe, .dout_o,
    .dout_oe, .wr_stb, .wr_addr, .wr_data, .rd_addr, .rd_data, .spi_locked, .lock_status,
    .ctrl_cfg1, .over_upper_limit, .under_lower_limit, .conv_done, .stat1_rd, .stat2_rd,
    .int_status1, .int_status2, .ara_req, .ara_resp, .ara_ack, .irq_o, .irq_oe);
  slw_host_model host_u (.sclk, .cs_b, .din, .dout_o, .dout_oe);
  assign rd_data = 8'hC0 | {2'h0, rd_addr};
  always @(posedge clk) if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp) err_total++;
  endtask : chk
  task automatic report_and_stop;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic pin(input logic [3:0] p, input logic [3:0] lim, input logic [7:0] cfg);
    @(posedge clk);
    {conv_done, stat1_rd, stat2_rd, ara_req} <= p;
    over_upper_limit <= lim;
    ctrl_cfg1 <= cfg;
    @(posedge clk);
    {conv_done, stat1_rd, stat2_rd, ara_req} <= 4'h0;
    repeat (4) @(posedge clk);
  endtask : pin
  task automatic frame(input logic [7:0] c, input logic [7:0] a, input int n);
    host_u.sel(1'b0);
    host_u.xfer(c, 8);
    host_u.xfer(a, 8);
    for (int k = 0; k < n; k += 8) host_u.xfer(8'(17 * (1 + k / 8)), n - k < 8 ? n - k : 8);
    host_u.sel(1'b1);
  endtask : frame
  initial begin
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk({spi_locked, lock_status[0], irq_oe}, 0);
    repeat (3) frame(8'h90, 8'h02, 8);
    repeat (6) @(posedge clk);
    chk({spi_locked, lock_status[0], 6'(wq.size())}, 8'hC0);
    frame(8'h90, 8'h3E, 24);
    chk(16'(wq.size()), 3);
    for (int i = 0; i < 3; i++) chk(wq[i], {6'h3E + 6'(i), 8'(17 * (i + 1))});
    wq.delete();
    frame(8'h90, 8'h05, 4);
    frame(8'h55, 8'h90, 16);
    frame(8'h90, 8'h3F, 0);
    chk(16'(wq.size()), 0);
    host_u.sel(1'b0);
    host_u.xfer(8'h91, 8);
    host_u.xfer(8'h00, 8);
    chk(host_u.rx, 8'hFF);
    host_u.xfer(8'h00, 8);
    chk(host_u.rx, 8'hC0);
    host_u.sel(1'b1);
    pin(4'h0, 4'h1, 8'h00);
    chk({irq_oe, |{int_status1, int_status2}}, 2'h3);
    pin(4'h8, 4'h0, 8'h00);
    pin(4'h1, 4'h0, 8'h00);
    chk({irq_oe, ara_resp}, {1'b1, DEV, 1'b1});
    pin(4'h6, 4'h0, 8'h00);
    pin(4'h8, 4'h0, 8'h40);
    chk(irq_oe, 1'b1);
    pin(4'h0, 4'h4, 8'h40);
    chk(irq_oe, 1'b0);
    pin(4'h0, 4'h4, 8'h20);
    chk(irq_oe, 1'b0);
    report_and_stop();
  end
endmodule : spi_slave_with_limit_alert_bench
